// ### hdl/ddc_dc_adder.sv
// Adds the Q0.11 DC dither amount into one modulator sample.
module ddc_dc_adder (
    input wire logic signed [ddc_pkg::SAMPLE_W-1:0] sample_i, // Modulator input sample
    input wire logic [ddc_pkg::DITHER_W-1:0] dither_i, // Unsigned dither code
    output logic signed [ddc_pkg::SAMPLE_W-1:0] sum_o // Sample plus dither, saturated
);
    import ddc_pkg::*;

    // Dither lands in the low part of the sample word
    wire logic signed [SAMPLE_W:0] offset_w; // One bit wider, never negative
    wire logic signed [SAMPLE_W:0] wide_sum_w; // Sum before saturation
    wire logic overflow_w; // Positive wrap after the add

    // Code times 2^-16 FS: a plain left shift, zero code adds zero
    assign offset_w = (SAMPLE_W+1)'(dither_i) << DITHER_SHIFT;
    assign wide_sum_w = (SAMPLE_W+1)'(sample_i) + offset_w;
    // Dither is never negative, so only the top can overflow
    assign overflow_w = wide_sum_w[SAMPLE_W] != wide_sum_w[SAMPLE_W-1];
    // Clip rather than wrap: a wrap would give a full-scale click
    assign sum_o = overflow_w ? {1'b0, {(SAMPLE_W-1){1'b1}}} : wide_sum_w[SAMPLE_W-1:0];
endmodule : ddc_dc_adder

// ### hdl/ddc_regs.sv
// Dither configuration registers and primary DC dither injection.
module ddc_regs (
    input wire logic clk_sys_i, // Core clock, 20 MHz
    input wire logic rstn_i, // Synchronous reset, active low
    input wire logic [7:0] reg_addr_i, // Control port register address
    input wire logic reg_wr_i, // Write strobe, one cycle
    input wire logic [ddc_pkg::DATA_W-1:0] reg_wdata_i, // Write data
    input wire logic reg_rd_i, // Read strobe, one cycle
    output logic [ddc_pkg::DATA_W-1:0] reg_rdata_o, // Read data, one cycle after strobe
    output logic reg_rvalid_o, // Read data valid pulse
    input wire logic sample_valid_i, // New modulator samples present
    input wire logic signed [ddc_pkg::SAMPLE_W-1:0] left_sample_i, // Left primary input
    input wire logic signed [ddc_pkg::SAMPLE_W-1:0] right_sample_i, // Right primary input
    output logic signed [ddc_pkg::SAMPLE_W-1:0] left_mod_o, // Left primary, dithered
    output logic signed [ddc_pkg::SAMPLE_W-1:0] right_mod_o, // Right primary, dithered
    output logic mod_valid_o, // Dithered samples valid pulse
    output logic [ddc_pkg::GAIN_W-1:0] left_secondary_ac_gain_o, // Left AC gain code
    output logic [ddc_pkg::GAIN_W-1:0] right_secondary_ac_gain_o, // Right AC gain code
    output logic left_secondary_ac_en_o, // Left AC dither enabled
    output logic right_secondary_ac_en_o, // Right AC dither enabled
    output logic [ddc_pkg::GAIN_W-1:0] left_secondary_dem_gain_o, // Left DEM gain code
    output logic [ddc_pkg::GAIN_W-1:0] right_secondary_dem_gain_o // Right DEM gain code
);
    import ddc_pkg::*;

    // Register map on the control port
    //   0x44: spare bits [7:3], left amount bits 10:8 in [2:0]
    //   0x45: left amount bits 7:0
    //   0x46: spare bits [7:3], right amount bits 10:8 in [2:0]
    //   0x47: right amount bits 7:0
    //   0x48: left AC, right AC, left DEM, right DEM gain codes
    // Gain codes: AC 00 eighth, 01 quarter, 11 off; DEM 00 half, 01 one
    // Reset: amounts zero, spare bits zero, every gain field 01
    // Amounts are unsigned: dither only ever pushes a sample upward
    // One code step is 2^-11 of 1/32 full scale, a left shift of seven
    // Bytes land one at a time, with no shadow copy
    // Hazard: a two-byte change passes one mixed amount to the adders
    // Limitation: mute the path, or accept one odd sample, on rewrites
    // Spare bits are kept only so that software reads back its writes

    // AC dither runs unless the code says off; used for both channels
    // Kept as a function so both channels decode the off code alike
    // Codes 00, 01 and 10 all leave AC dither running
    function automatic logic ac_enabled(input logic [GAIN_W-1:0] code);
        ac_enabled = (code != AC_GAIN_OFF);
    endfunction : ac_enabled

    // Stored fields
    // Only the amount bits feed the adders; spare bits never do
    logic [RSVD_W-1:0] left_rsvd_reg; // Reserved bits, kept for readback
    logic [RSVD_W-1:0] right_rsvd_reg; // Upper bits of the right first byte, readback only
    logic [DITHER_W-1:0] left_primary_dc_dither_reg; // Left 11-bit amount
    logic [DITHER_W-1:0] right_primary_dc_dither_reg; // Right 11-bit amount
    logic [DATA_W-1:0] secondary_dither_gains_reg; // Four packed gains

    // Address decode
    // Full eight-bit compare: aliases would let stray writes move dither
    // One hit per mapped register, unmapped ones hit nothing
    wire logic hit_left_upper_w = reg_addr_i == ADDR_LEFT_UPPER;
    wire logic hit_left_lower_w = reg_addr_i == ADDR_LEFT_LOWER;
    wire logic hit_right_first_w = reg_addr_i == ADDR_RIGHT_FIRST;
    wire logic hit_right_second_w = reg_addr_i == ADDR_RIGHT_SECOND;
    wire logic hit_sec_gains_w = reg_addr_i == ADDR_SEC_GAINS;

    // Write hits: strobe and address together, one per register
    // A write to an unmapped address matches none and is dropped
    // Strobe is one cycle wide, so each hit is exactly one write
    wire logic wr_left_upper_w;
    wire logic wr_left_lower_w;
    wire logic wr_right_first_w;
    wire logic wr_right_second_w;
    wire logic wr_sec_gains_w;
    assign wr_left_upper_w = reg_wr_i && hit_left_upper_w;
    assign wr_left_lower_w = reg_wr_i && hit_left_lower_w;
    assign wr_right_first_w = reg_wr_i && hit_right_first_w;
    assign wr_right_second_w = reg_wr_i && hit_right_second_w;
    assign wr_sec_gains_w = reg_wr_i && hit_sec_gains_w;

    // Next values: each byte write touches only its own slice
    wire logic [RSVD_W-1:0] left_rsvd_next;
    wire logic [RSVD_W-1:0] right_rsvd_next;
    wire logic [DITHER_W-1:0] left_dither_next;
    wire logic [DITHER_W-1:0] right_dither_next;
    wire logic [DATA_W-1:0] sec_gains_next;

    // Spare bits of the first bytes, stored and read back as written
    assign left_rsvd_next = wr_left_upper_w ?
        reg_wdata_i[DATA_W-1:UPPER_W] : left_rsvd_reg;
    assign right_rsvd_next = wr_right_first_w ?
        reg_wdata_i[DATA_W-1:UPPER_W] : right_rsvd_reg;
    // Upper register carries amount bits 10:8, lower carries 7:0
    assign left_dither_next = {
        wr_left_upper_w ? reg_wdata_i[UPPER_W-1:0]
            : left_primary_dc_dither_reg[DITHER_W-1:DATA_W],
        wr_left_lower_w ? reg_wdata_i
            : left_primary_dc_dither_reg[DATA_W-1:0]};
    // Right amount: first register upper three bits, second the low byte
    assign right_dither_next = {
        wr_right_first_w ? reg_wdata_i[UPPER_W-1:0]
            : right_primary_dc_dither_reg[DITHER_W-1:DATA_W],
        wr_right_second_w ? reg_wdata_i
            : right_primary_dc_dither_reg[DATA_W-1:0]};
    // Reserved DEM codes are stored as written; software keeps off them
    // Checking them here would cost a compare and hide what was written
    assign sec_gains_next = wr_sec_gains_w ?
        reg_wdata_i : secondary_dither_gains_reg;

    // Read mux; unmapped addresses read zero
    // Selects from stored state only, so a same-cycle write reads old
    // Unmapped reads give a fixed value, never stale data
    wire logic [DATA_W-1:0] rdata_next;
    assign rdata_next =
        hit_left_upper_w ? {left_rsvd_reg, left_primary_dc_dither_reg[DITHER_W-1:DATA_W]} :
        hit_left_lower_w ? left_primary_dc_dither_reg[DATA_W-1:0] :
        hit_right_first_w ? {right_rsvd_reg, right_primary_dc_dither_reg[DITHER_W-1:DATA_W]} :
        hit_right_second_w ? right_primary_dc_dither_reg[DATA_W-1:0] :
        hit_sec_gains_w ? secondary_dither_gains_reg : READ_UNMAPPED;

    // Register storage, all amounts clear at reset
    // Synchronous reset only: the core clock runs whenever reset is applied
    // No clear on read or write-one: every field is plain read/write
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin // Reset: no DC dither, gains at 01
            left_rsvd_reg <= RSVD_RESET;
            right_rsvd_reg <= RSVD_RESET;
            left_primary_dc_dither_reg <= DITHER_RESET;
            right_primary_dc_dither_reg <= DITHER_RESET;
            secondary_dither_gains_reg <= {GAIN_RESET, GAIN_RESET, GAIN_RESET, GAIN_RESET};
        end else begin
            left_rsvd_reg <= left_rsvd_next;
            right_rsvd_reg <= right_rsvd_next;
            left_primary_dc_dither_reg <= left_dither_next;
            right_primary_dc_dither_reg <= right_dither_next;
            secondary_dither_gains_reg <= sec_gains_next;
        end
    end

    // Read answer, registered
    // Data holds between reads so a slow master may sample it late
    // Valid is a one-cycle pulse that marks the fresh answer
    // Reads have no side effects, so repeated reads are harmless
    // Read data only moves on a read, which keeps the port quiet
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= READ_UNMAPPED;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rdata_next : reg_rdata_o;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // Field slices of the gain register
    // Fixed positions from the package, one slice per field
    // A moved field only needs a change of the package constant
    wire logic [GAIN_W-1:0] left_ac_w = secondary_dither_gains_reg[LEFT_AC_LSB +: GAIN_W];
    wire logic [GAIN_W-1:0] right_ac_w = secondary_dither_gains_reg[RIGHT_AC_LSB +: GAIN_W];
    wire logic [GAIN_W-1:0] left_dem_w = secondary_dither_gains_reg[LEFT_DEM_LSB +: GAIN_W];
    wire logic [GAIN_W-1:0] right_dem_w = secondary_dither_gains_reg[RIGHT_DEM_LSB +: GAIN_W];
    // AC enables decoded once per channel
    wire logic left_ac_en_w = ac_enabled(left_ac_w);
    wire logic right_ac_en_w = ac_enabled(right_ac_w);

    // Gain outputs, one flop after the register
    // The extra flop keeps every top output straight from a flip-flop
    // Cost: gains take effect one cycle after the write
    // Enables share that flop, so code and enable never disagree
    // Reset values match the register reset, so outputs never glitch
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            left_secondary_ac_gain_o <= GAIN_RESET;
            right_secondary_ac_gain_o <= GAIN_RESET;
            left_secondary_ac_en_o <= 1'b1;
            right_secondary_ac_en_o <= 1'b1;
            left_secondary_dem_gain_o <= GAIN_RESET;
            right_secondary_dem_gain_o <= GAIN_RESET;
        end else begin
            left_secondary_ac_gain_o <= left_ac_w;
            right_secondary_ac_gain_o <= right_ac_w;
            left_secondary_ac_en_o <= left_ac_en_w;
            right_secondary_ac_en_o <= right_ac_en_w;
            left_secondary_dem_gain_o <= left_dem_w;
            right_secondary_dem_gain_o <= right_dem_w;
        end
    end

    // Dither injection, one adder per channel
    // Index 0 is left, index 1 is right, throughout this section
    // Adders are plain logic; only the output stage below is clocked
    // Saturation lives in the adder, so no wrap reaches the modulator
    wire logic signed [SAMPLE_W-1:0] sample_w [2];
    wire logic [DITHER_W-1:0] dither_w [2];
    wire logic signed [SAMPLE_W-1:0] sum_w [2];
    assign sample_w[0] = left_sample_i;
    assign sample_w[1] = right_sample_i;
    assign dither_w[0] = left_primary_dc_dither_reg;
    assign dither_w[1] = right_primary_dc_dither_reg;

    // Same adder for both channels, built by a generate loop
    // Each instance sees only its own channel's amount
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        ddc_dc_adder u_add (
            .sample_i(sample_w[ch]),
            .dither_i(dither_w[ch]),
            .sum_o(sum_w[ch])
        );
    end

    // Output samples held between valid pulses
    // Dither in use is whatever is stored at the taking edge
    // Holding the old pair keeps the modulator input steady
    // Valid is the input strobe delayed by one cycle
    // No back-pressure: a new sample every cycle is taken
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            left_mod_o <= '0;
            right_mod_o <= '0;
            mod_valid_o <= 1'b0;
        end else begin
            left_mod_o <= sample_valid_i ? sum_w[0] : left_mod_o;
            right_mod_o <= sample_valid_i ? sum_w[1] : right_mod_o;
            mod_valid_o <= sample_valid_i;
        end
    end
endmodule : ddc_regs

// ### inc/ddc_pkg.sv
// Constants for the dither configuration register bank.
package ddc_pkg;
    // Register addresses on the control port
    localparam logic [7:0] ADDR_LEFT_UPPER = 8'h44;
    localparam logic [7:0] ADDR_LEFT_LOWER = 8'h45;
    localparam logic [7:0] ADDR_RIGHT_FIRST = 8'h46;
    localparam logic [7:0] ADDR_RIGHT_SECOND = 8'h47;
    localparam logic [7:0] ADDR_SEC_GAINS = 8'h48;
    // Widths
    localparam int DATA_W = 8;
    localparam int DITHER_W = 11;
    localparam int UPPER_W = 3;
    localparam int RSVD_W = 5;
    localparam int GAIN_W = 2;
    localparam int SAMPLE_W = 24;
    // 1.0 in Q0.11 equals 1/32 FS: code lsb weighs 2^-16 of full scale
    localparam int FS_FRAC_BITS = 5;
    localparam int DITHER_SHIFT = SAMPLE_W - 1 - DITHER_W - FS_FRAC_BITS;
    // Field positions in the secondary gain register
    localparam int LEFT_AC_LSB = 6;
    localparam int RIGHT_AC_LSB = 4;
    localparam int LEFT_DEM_LSB = 2;
    localparam int RIGHT_DEM_LSB = 0;
    // Reset values
    localparam logic [DITHER_W-1:0] DITHER_RESET = 11'h000;
    localparam logic [RSVD_W-1:0] RSVD_RESET = 5'h00;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 2'h1;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
    // Gain codes
    localparam logic [GAIN_W-1:0] AC_GAIN_EIGHTH = 2'h0;
    localparam logic [GAIN_W-1:0] AC_GAIN_QUARTER = 2'h1;
    localparam logic [GAIN_W-1:0] AC_GAIN_OFF = 2'h3;
    localparam logic [GAIN_W-1:0] DEM_GAIN_HALF = 2'h0;
    localparam logic [GAIN_W-1:0] DEM_GAIN_ONE = 2'h1;
endpackage : ddc_pkg

// ### verif/ddc_regs_chk.sv
// Port-level assertions for the dither register bank.
module ddc_regs_chk (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [ddc_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [ddc_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic sample_valid_i,
    input wire logic signed [ddc_pkg::SAMPLE_W-1:0] left_mod_o,
    input wire logic mod_valid_o,
    input wire logic [ddc_pkg::GAIN_W-1:0] left_secondary_ac_gain_o,
    input wire logic [ddc_pkg::GAIN_W-1:0] right_secondary_ac_gain_o,
    input wire logic left_secondary_ac_en_o,
    input wire logic right_secondary_ac_en_o,
    input wire logic [ddc_pkg::GAIN_W-1:0] left_secondary_dem_gain_o,
    input wire logic [ddc_pkg::GAIN_W-1:0] right_secondary_dem_gain_o
);
    import ddc_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Write, one idle cycle, then a clean read of the same place
    sequence s_wr(logic [7:0] a); reg_wr_i && reg_addr_i == a; endsequence
    sequence s_rd(logic [7:0] a); reg_rd_i && !reg_wr_i && reg_addr_i == a; endsequence
    // Mask covers bits that are not kept
    property p_back(logic [7:0] a, logic [7:0] m);
        s_wr(a) ##1 !reg_wr_i ##1 s_rd(a) |=> reg_rdata_o == ($past(reg_wdata_i, 3) & m);
    endproperty
    a_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read got no valid pulse");
    a_valid_caused: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("valid pulse without read");
    a_left_back: assert property (p_back(ADDR_LEFT_LOWER, 8'hff))
        else $error("left lower byte lost");
    a_right_first_back: assert property (p_back(ADDR_RIGHT_FIRST, 8'hff))
        else $error("right first byte wrong");
    a_right_second_back: assert property (p_back(ADDR_RIGHT_SECOND, 8'hff))
        else $error("right second byte lost");
    // Field order inside the gain register
    a_gains_follow: assert property (s_wr(ADDR_SEC_GAINS) |-> ##2 {left_secondary_ac_gain_o,
        right_secondary_ac_gain_o, left_secondary_dem_gain_o, right_secondary_dem_gain_o}
        == $past(reg_wdata_i, 2)) else $error("gain fields misplaced");
    a_ac_off_code: assert property ((left_secondary_ac_en_o ==
        (left_secondary_ac_gain_o != AC_GAIN_OFF)) && (right_secondary_ac_en_o ==
        (right_secondary_ac_gain_o != AC_GAIN_OFF))) else $error("ac enable wrong");
    a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h44 ||
        reg_addr_i > 8'h48) |=> reg_rdata_o == READ_UNMAPPED) else $error("unmapped read");
    a_mod_pulse: assert property (sample_valid_i |=> mod_valid_o)
        else $error("sample not answered");
    a_mod_holds: assert property (!sample_valid_i |=> !mod_valid_o && $stable(left_mod_o))
        else $error("output moved without sample");
endmodule : ddc_regs_chk

bind ddc_regs ddc_regs_chk u_chk (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .sample_valid_i, .left_mod_o, .mod_valid_o,
    .left_secondary_ac_gain_o, .right_secondary_ac_gain_o, .left_secondary_ac_en_o,
    .right_secondary_ac_en_o, .left_secondary_dem_gain_o, .right_secondary_dem_gain_o);

// ### verif/test_ddc_regs.sv
// Self-checking bench for the dither register bank.
module test_ddc_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import ddc_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sample_valid_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic signed [SAMPLE_W-1:0] left_sample_i = 24'h0, right_sample_i = 24'h0, left_mod_o;
    logic signed [SAMPLE_W-1:0] right_mod_o;
    logic reg_rvalid_o, mod_valid_o, left_secondary_ac_en_o, right_secondary_ac_en_o;
    logic [1:0] left_secondary_ac_gain_o, right_secondary_ac_gain_o;
    logic [1:0] left_secondary_dem_gain_o, right_secondary_dem_gain_o;
    logic [7:0] gains[5] = '{8'h00, 8'h55, 8'hf0, 8'hc4, 8'h31}; // Legal gain codes only
    logic [10:0] codes[4] = '{11'h000, 11'h001, 11'h002, 11'h734};
    int n_fail = 0;
    int n_tests = 0;
    ddc_regs u_dut (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
        .reg_rdata_o, .reg_rvalid_o, .sample_valid_i, .left_sample_i, .right_sample_i,
        .left_mod_o, .right_mod_o, .mod_valid_o, .left_secondary_ac_gain_o,
        .right_secondary_ac_gain_o, .left_secondary_ac_en_o, .right_secondary_ac_en_o,
        .left_secondary_dem_gain_o, .right_secondary_dem_gain_o);
    // Compare one value, count it
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        @(negedge clk_sys_i) reg_wr_i = 1'b0;
    endtask : wr
    // Read strobe; answer checked in the one cycle after the taking edge, while valid stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge clk_sys_i) reg_rd_i = 1'b0;
        chk(reg_rvalid_o, 1'b1);
        chk(reg_rdata_o, exp);
    endtask : rd
    // Push one sample pair and compare the dithered pair
    task automatic samp(input logic [23:0] l, r, el, er);
        @(negedge clk_sys_i) {sample_valid_i, left_sample_i, right_sample_i} = {1'b1, l, r};
        @(negedge clk_sys_i) sample_valid_i = 1'b0;
        chk({mod_valid_o, left_mod_o, right_mod_o}, {1'b1, el, er});
    endtask : samp
    // Reset held six cycles, then defaults checked
    task automatic reset_check;
        if (rstn_i) @(negedge clk_sys_i);
        rstn_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        for (int a = 8'h44; a < 8'h48; a++) rd(8'(a), 8'h00);
        rd(ADDR_SEC_GAINS, 8'h55);
        chk({left_secondary_ac_gain_o, right_secondary_ac_gain_o, left_secondary_dem_gain_o,
            right_secondary_dem_gain_o}, 8'h55);
        chk({left_secondary_ac_en_o, right_secondary_ac_en_o}, 2'b11);
        samp(24'h000100, 24'h000200, 24'h000100, 24'h000200);
        $display("test reset defaults done");
    endtask : reset_check
    // Verdict and end of run
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #(5000 * 50);
        n_fail++;
        conclude();
    end
    initial begin
        reset_check();
        // Upper byte leads; its spare bits are kept
        wr(ADDR_LEFT_UPPER, 8'hfd);
        wr(ADDR_LEFT_LOWER, 8'h12);
        rd(ADDR_LEFT_LOWER, 8'h12);
        rd(ADDR_LEFT_UPPER, 8'hfd);
        samp(24'h000100, 24'h0, 24'h000100 + (24'h512 << DITHER_SHIFT), 24'h0);
        $display("test left dither done");
        wr(ADDR_RIGHT_FIRST, 8'hff);
        rd(ADDR_RIGHT_FIRST, 8'hff);
        // Zero, one and two steps, then a large code across zero
        foreach (codes[i]) begin
            wr(ADDR_RIGHT_FIRST, {5'h00, codes[i][10:8]});
            wr(ADDR_RIGHT_SECOND, codes[i][7:0]);
            rd(ADDR_RIGHT_SECOND, codes[i][7:0]);
            samp(24'h0, 24'hfff000, 24'h512 << DITHER_SHIFT,
                24'hfff000 + (24'(codes[i]) << DITHER_SHIFT));
        end
        $display("test right dither done");
        wr(ADDR_LEFT_UPPER, 8'h07);
        wr(ADDR_LEFT_LOWER, 8'hff);
        samp(24'h7fff00, 24'h0, 24'h7fffff, 24'h734 << DITHER_SHIFT);
        $display("test saturation done");
        foreach (gains[i]) begin
            wr(ADDR_SEC_GAINS, gains[i]);
            @(posedge clk_sys_i) #1;
            chk({left_secondary_ac_gain_o, right_secondary_ac_gain_o, left_secondary_dem_gain_o,
                right_secondary_dem_gain_o}, gains[i]);
            chk({left_secondary_ac_en_o, right_secondary_ac_en_o},
                {gains[i][7:6] != 2'h3, gains[i][5:4] != 2'h3});
            rd(ADDR_SEC_GAINS, gains[i]);
        end
        $display("test gains done");
        wr(8'h49, 8'haa);
        rd(8'h49, READ_UNMAPPED);
        rd(8'h43, READ_UNMAPPED);
        $display("test unmapped done");
        reset_check();
        conclude();
    end
endmodule : test_ddc_regs
